// file: hdl/supply_monitor_consts.vh
// constants for the supply monitor and reset logic
`ifndef SUPPLY_MONITOR_CONSTS_VH
`define SUPPLY_MONITOR_CONSTS_VH

// ============================================================
// register offsets
`define OFS_LEVEL_SEL 8'h00
`define OFS_MON1_CTL 8'h04
`define OFS_MON2_CTL 8'h08
`define OFS_MON1_STAT 8'h0C
`define OFS_MON2_STAT 8'h10
`define OFS_RST_CAUSE 8'h14
`define OFS_INT_STAT 8'h18
`define OFS_INT_MASK 8'h1C
`define OFS_SW_RESET 8'h20

// ============================================================
// level select fields
`define LVL1_LO 0
`define LVL1_HI 3
`define LVL2_LO 4
`define LVL2_HI 5
`define LVL1_MAX 4'h8
`define LVL0_MAX 2'h2

// ============================================================
// channel control fields
`define CTL_RST_EN 0
`define CTL_REL_FALL 1
`define CTL_INT_EN 2
`define CTL_NMI_SEL 3
`define CTL_EDGE_LO 4
`define CTL_EDGE_HI 5
`define EDGE_FALL 2'h0
`define EDGE_RISE 2'h1

// ============================================================
// status fields
`define STAT_CROSS 0
`define STAT_LEVEL 1
`define INT_IRQ1 0
`define INT_IRQ2 1
`define INT_NMI1 2
`define INT_NMI2 3

// ============================================================
// reset cause bits
`define CAUSE_PIN 0
`define CAUSE_POR 1
`define CAUSE_MON0 2
`define CAUSE_MON1 3
`define CAUSE_MON2 4
`define CAUSE_WDT 5
`define CAUSE_SW 6

// ============================================================
// reset values and key
`define RV_LEVEL1 4'h0
`define RV_LEVEL2 2'h0
`define RV_CTL 6'h00
`define RV_MASK 2'h0
`define SW_RESET_KEY 8'hA5

// ============================================================
// timing
`define CLK_PERIOD_NS 50
`define RESTART_NS 100000
`define RESTART_CYC ((`RESTART_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: hdl/supply_monitor_reset_logic.v
// supply monitor channels, reset sequencer and register file
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "supply_monitor_consts.vh"
module supply_monitor_reset_logic (
    // clock and reset
    input wire clk,
    input wire rst,
    // pins and analog comparators
    input wire ext_reset_pin_n,
    input wire por_above,
    input wire mon0_above,
    input wire mon1_above,
    input wire mon2_above,
    // option word and watchdog
    input wire [1:0] option_config_word_1,
    input wire wdt_underflow,
    input wire wdt_refresh_err,
    // register port
    input wire [7:0] addr,
    input wire [7:0] wr_data,
    input wire wr_en,
    input wire rd_en,
    output reg [7:0] rd_data,
    // level selects to comparators
    output reg [1:0] monitor0_level_select,
    output reg [3:0] monitor1_level_field,
    output reg [1:0] monitor2_level_field,
    // reset and interrupts
    output reg sys_reset,
    output reg irq,
    output reg nmi
);

// ============================================================
// sequencer states
localparam [1:0] ST_RUN = 2'b00;
localparam [1:0] ST_HOLD = 2'b01;
localparam [1:0] ST_DELAY = 2'b10;
localparam integer RESTART_INT = `RESTART_CYC;
localparam [11:0] RESTART_CYCLES = RESTART_INT[11:0];
localparam [11:0] CNT_ONE = 12'h001;
localparam [11:0] CNT_ZERO = 12'h000;

// ============================================================
// functions
function edge_hit;
    input [1:0] sel;
    input rise;
    input fall;
    begin
        case (sel)
            `EDGE_FALL: edge_hit = fall;
            `EDGE_RISE: edge_hit = rise;
            default: edge_hit = rise | fall;
        endcase
    end
endfunction

function [7:0] w1c;
    input [7:0] cur;
    input [7:0] data;
    input hit;
    begin
        w1c = hit ? (cur & ~data) : cur;
    end
endfunction

// ============================================================
// synchronised inputs
wire [4:0] sy;
reg por_prev_r;
reg mon1_prev_r;
reg mon2_prev_r;

sync_two_flop #(
    .WIDTH(5)
) u_sync (
    .clk(clk),
    .rst(rst),
    // idle-high levels except por_above go in inverted so the flops' reset reads as idle
    .async_in({~ext_reset_pin_n, por_above, ~mon0_above, ~mon1_above,
        ~mon2_above}),
    .sync_out(sy)
);

wire pin_n_s = ~sy[4];
wire por_s = sy[3];
wire mon0_s = ~sy[2];
wire mon1_s = ~sy[1];
wire mon2_s = ~sy[0];

wire por_rise = por_s & ~por_prev_r;
wire mon1_rise = mon1_s & ~mon1_prev_r;
wire mon1_fall = ~mon1_s & mon1_prev_r;
wire mon2_rise = mon2_s & ~mon2_prev_r;
wire mon2_fall = ~mon2_s & mon2_prev_r;

always @(posedge clk or posedge rst) begin
    if (rst) begin
        por_prev_r <= 1'b0;
        mon1_prev_r <= 1'b1;
        mon2_prev_r <= 1'b1;
    end else begin
        por_prev_r <= por_s;
        mon1_prev_r <= mon1_s;
        mon2_prev_r <= mon2_s;
    end
end

// ============================================================
// configuration registers
reg [5:0] ctl1_r;
reg [5:0] ctl2_r;
reg [1:0] mask_r;
reg strap_done_r;

wire wr_lvl = wr_en && (addr == `OFS_LEVEL_SEL);
wire wr_ctl1 = wr_en && (addr == `OFS_MON1_CTL);
wire wr_ctl2 = wr_en && (addr == `OFS_MON2_CTL);
wire wr_st1 = wr_en && (addr == `OFS_MON1_STAT);
wire wr_st2 = wr_en && (addr == `OFS_MON2_STAT);
wire wr_cause = wr_en && (addr == `OFS_RST_CAUSE);
wire wr_ist = wr_en && (addr == `OFS_INT_STAT);
wire wr_mask = wr_en && (addr == `OFS_INT_MASK);
wire wr_sw = wr_en && (addr == `OFS_SW_RESET);
wire [3:0] lvl1_wr = wr_data[`LVL1_HI:`LVL1_LO];

// option word is a strap: caught once, right after reset release
always @(posedge clk or posedge rst) begin
    if (rst) begin
        strap_done_r <= 1'b0;
        monitor0_level_select <= 2'h0;
    end else if (!strap_done_r) begin
        strap_done_r <= 1'b1;
        // code 3 has no level of its own; mapped to the top one
        if (option_config_word_1 > `LVL0_MAX) begin
            monitor0_level_select <= `LVL0_MAX;
        end else begin
            monitor0_level_select <= option_config_word_1;
        end
    end
end

always @(posedge clk or posedge rst) begin
    if (rst) begin
        monitor1_level_field <= `RV_LEVEL1;
        monitor2_level_field <= `RV_LEVEL2;
        ctl1_r <= `RV_CTL;
        ctl2_r <= `RV_CTL;
        mask_r <= `RV_MASK;
    end else begin
        if (wr_lvl) begin
            // codes past the ninth level are dropped, field keeps value
            if (lvl1_wr <= `LVL1_MAX) begin
                monitor1_level_field <= lvl1_wr;
            end
            monitor2_level_field <= wr_data[`LVL2_HI:`LVL2_LO];
        end
        if (wr_ctl1) begin
            ctl1_r <= wr_data[`CTL_EDGE_HI:0];
        end
        if (wr_ctl2) begin
            ctl2_r <= wr_data[`CTL_EDGE_HI:0];
        end
        if (wr_mask) begin
            mask_r <= wr_data[`INT_IRQ2:`INT_IRQ1];
        end
    end
end

// ============================================================
// crossing flags and interrupt status
reg cross1_r;
reg cross2_r;
reg [3:0] ist_r;
reg [3:0] ist_nxt;
reg [3:0] ev;
wire [7:0] ist_kept = w1c({4'h0, ist_r}, wr_data, wr_ist);

wire ev1 = ctl1_r[`CTL_INT_EN] &&
    edge_hit(ctl1_r[`CTL_EDGE_HI:`CTL_EDGE_LO], mon1_rise, mon1_fall);
wire ev2 = ctl2_r[`CTL_INT_EN] &&
    edge_hit(ctl2_r[`CTL_EDGE_HI:`CTL_EDGE_LO], mon2_rise, mon2_fall);

always @* begin
    ev = 4'h0;
    ev[`INT_IRQ1] = ev1 & ~ctl1_r[`CTL_NMI_SEL];
    ev[`INT_NMI1] = ev1 & ctl1_r[`CTL_NMI_SEL];
    ev[`INT_IRQ2] = ev2 & ~ctl2_r[`CTL_NMI_SEL];
    ev[`INT_NMI2] = ev2 & ctl2_r[`CTL_NMI_SEL];
    // set wins over a clear in the same cycle
    ist_nxt = ist_kept[3:0] | ev;
end

always @(posedge clk or posedge rst) begin
    if (rst) begin
        cross1_r <= 1'b0;
        cross2_r <= 1'b0;
        ist_r <= 4'h0;
        irq <= 1'b0;
        nmi <= 1'b0;
    end else begin
        cross1_r <= (cross1_r & ~(wr_st1 & wr_data[`STAT_CROSS])) |
            mon1_rise | mon1_fall;
        cross2_r <= (cross2_r & ~(wr_st2 & wr_data[`STAT_CROSS])) |
            mon2_rise | mon2_fall;
        ist_r <= ist_nxt;
        irq <= |(ist_nxt[`INT_IRQ2:`INT_IRQ1] & mask_r);
        // non-maskable path ignores the mask on purpose
        nmi <= ist_nxt[`INT_NMI1] | ist_nxt[`INT_NMI2];
    end
end

// ============================================================
// reset sources
// level sources hold reset; pulse sources only start the delay
wire hold_pin = ~pin_n_s;
wire hold_mon0 = ~mon0_s;
wire hold_mon1 = ctl1_r[`CTL_RST_EN] & ~ctl1_r[`CTL_REL_FALL] & ~mon1_s;
wire hold_mon2 = ctl2_r[`CTL_RST_EN] & ~ctl2_r[`CTL_REL_FALL] & ~mon2_s;
wire trig_mon1 = ctl1_r[`CTL_RST_EN] & ctl1_r[`CTL_REL_FALL] & mon1_fall;
wire trig_mon2 = ctl2_r[`CTL_RST_EN] & ctl2_r[`CTL_REL_FALL] & mon2_fall;
wire trig_wdt = wdt_underflow | wdt_refresh_err;
wire trig_sw = wr_sw && (wr_data == `SW_RESET_KEY);

wire hold_any = hold_pin | hold_mon0 | hold_mon1 | hold_mon2;
wire trig_any = por_rise | trig_mon1 | trig_mon2 | trig_wdt | trig_sw;

reg [6:0] cause_r;
reg [6:0] cause_ev;
wire [7:0] cause_kept = w1c({1'b0, cause_r}, wr_data, wr_cause);

always @* begin
    cause_ev = 7'h00;
    cause_ev[`CAUSE_PIN] = hold_pin;
    cause_ev[`CAUSE_POR] = por_rise;
    cause_ev[`CAUSE_MON0] = hold_mon0;
    cause_ev[`CAUSE_MON1] = hold_mon1 | trig_mon1;
    cause_ev[`CAUSE_MON2] = hold_mon2 | trig_mon2;
    cause_ev[`CAUSE_WDT] = trig_wdt;
    cause_ev[`CAUSE_SW] = trig_sw;
end

always @(posedge clk or posedge rst) begin
    if (rst) begin
        cause_r <= 7'h00;
    end else begin
        cause_r <= cause_kept[6:0] | cause_ev;
    end
end

// ============================================================
// reset sequencer
reg [1:0] state_r;
reg [1:0] state_nxt;
reg [11:0] cnt_r;
reg [11:0] cnt_nxt;

always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
        ST_RUN: begin
            if (hold_any) begin
                state_nxt = ST_HOLD;
            end else if (trig_any) begin
                state_nxt = ST_DELAY;
                cnt_nxt = RESTART_CYCLES;
            end
        end
        ST_HOLD: begin
            // release delay counts from the moment the hold drops
            if (!hold_any) begin
                state_nxt = ST_DELAY;
                cnt_nxt = RESTART_CYCLES;
            end
        end
        ST_DELAY: begin
            if (hold_any) begin
                state_nxt = ST_HOLD;
            end else if (trig_any) begin
                cnt_nxt = RESTART_CYCLES;
            end else if (cnt_r == CNT_ONE) begin
                state_nxt = ST_RUN;
                cnt_nxt = CNT_ZERO;
            end else begin
                cnt_nxt = cnt_r - CNT_ONE;
            end
        end
        default: begin
            state_nxt = ST_HOLD;
            cnt_nxt = CNT_ZERO;
        end
    endcase
end

always @(posedge clk or posedge rst) begin
    if (rst) begin
        state_r <= ST_HOLD;
        cnt_r <= CNT_ZERO;
        sys_reset <= 1'b1;
    end else begin
        state_r <= state_nxt;
        cnt_r <= cnt_nxt;
        sys_reset <= (state_nxt != ST_RUN);
    end
end

// ============================================================
// read port
reg [7:0] rd_mux;

always @* begin
    rd_mux = 8'h00;
    case (addr)
        `OFS_LEVEL_SEL: begin
            rd_mux[`LVL1_HI:`LVL1_LO] = monitor1_level_field;
            rd_mux[`LVL2_HI:`LVL2_LO] = monitor2_level_field;
        end
        `OFS_MON1_CTL: rd_mux[`CTL_EDGE_HI:0] = ctl1_r;
        `OFS_MON2_CTL: rd_mux[`CTL_EDGE_HI:0] = ctl2_r;
        `OFS_MON1_STAT: begin
            rd_mux[`STAT_CROSS] = cross1_r;
            rd_mux[`STAT_LEVEL] = mon1_s;
        end
        `OFS_MON2_STAT: begin
            rd_mux[`STAT_CROSS] = cross2_r;
            rd_mux[`STAT_LEVEL] = mon2_s;
        end
        `OFS_RST_CAUSE: rd_mux[`CAUSE_SW:0] = cause_r;
        `OFS_INT_STAT: rd_mux[`INT_NMI2:0] = ist_r;
        `OFS_INT_MASK: rd_mux[`INT_IRQ2:`INT_IRQ1] = mask_r;
        default: rd_mux = 8'h00;
    endcase
end

// data stand only in the cycle after the strobe
always @(posedge clk or posedge rst) begin
    if (rst) begin
        rd_data <= 8'h00;
    end else if (rd_en) begin
        rd_data <= rd_mux;
    end else begin
        rd_data <= 8'h00;
    end
end

endmodule // supply_monitor_reset_logic

// file: hdl/sync_two_flop.v
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module sync_two_flop #(
    parameter WIDTH = 5
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // levels
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] meta_r;

// ============================================================
// stages
// first stage feeds the second stage only
always @(posedge clk or posedge rst) begin
    if (rst) begin
        meta_r <= {WIDTH{1'b0}};
        sync_out <= {WIDTH{1'b0}};
    end else begin
        meta_r <= async_in;
        sync_out <= meta_r;
    end
end

endmodule // sync_two_flop

// file: test/supply_model.sv
// behavioural supply comparators and reset pin
`timescale 1ns/1ps
module supply_model (
    // supply in 100 mV steps and pin request
    input wire [7:0] vcc,
    input wire pin_low,
    // level selects from the block
    input wire [1:0] monitor0_level_select,
    input wire [3:0] monitor1_level_field,
    input wire [1:0] monitor2_level_field,
    // comparator outputs and pin
    output wire por_above,
    output wire mon0_above,
    output wire mon1_above,
    output wire mon2_above,
    output wire ext_reset_pin_n
);
    // coarse 100 mV steps keep the tests short, no hysteresis modelled
    assign por_above = vcc > 8'h0F;
    assign mon0_above = vcc > 8'h14 + {6'h00, monitor0_level_select};
    assign mon1_above = vcc > 8'h1E + {4'h0, monitor1_level_field};
    assign mon2_above = vcc > 8'h1A + {6'h00, monitor2_level_field};
    // pulled up when nobody drives it low
    assign ext_reset_pin_n = !pin_low;
endmodule // supply_model

// file: test/supply_monitor_checker.sv
// port assertions for the supply monitor reset logic
`timescale 1ns/1ps
module supply_monitor_checker (
    // clock and reset
    input wire clk,
    input wire rst,
    // pins, comparators, watchdog
    input wire ext_reset_pin_n,
    input wire mon0_above,
    input wire wdt_underflow,
    input wire wdt_refresh_err,
    // register port
    input wire [7:0] addr,
    input wire [7:0] wr_data,
    input wire wr_en,
    input wire rd_en,
    input wire [7:0] rd_data,
    // outputs
    input wire [1:0] monitor0_level_select,
    input wire [3:0] monitor1_level_field,
    input wire sys_reset
);
    // ============================================================
    // cycles the reset output has stood high, saturating
    reg [11:0] hi_r;
    always @(posedge clk or posedge rst) begin
        if (rst)
            hi_r <= 12'h000;
        else if (!sys_reset)
            hi_r <= 12'h000;
        else if (hi_r != 12'hFFF)
            hi_r <= hi_r + 12'h001;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ============================================================
    // assertions
    a_pin_holds: assert property (
        !ext_reset_pin_n [*5] |-> sys_reset)
        else $error("pin held low without reset");
    a_wdt_under: assert property (
        wdt_underflow |-> ##[1:3] sys_reset)
        else $error("underflow gave no reset");
    a_wdt_refresh: assert property (
        wdt_refresh_err |-> ##[1:3] sys_reset)
        else $error("refresh error gave no reset");
    a_sw_key: assert property (
        wr_en && addr == 8'h20 && wr_data == 8'hA5 |-> ##[1:3] sys_reset)
        else $error("key write gave no reset");
    a_mon0_hold: assert property (
        !mon0_above [*5] |-> sys_reset)
        else $error("low supply without reset");
    a_restart_delay: assert property (
        $fell(sys_reset) |-> hi_r >= 12'h7CF)
        else $error("reset released too early");
    a_level0_fixed: assert property (
        !$past(rst, 2) |->
        $stable(monitor0_level_select) && monitor0_level_select != 2'h3)
        else $error("channel 0 level moved or out of range");
    a_level1_range: assert property (
        monitor1_level_field <= 4'h8)
        else $error("channel 1 level out of range");
    a_read_idle: assert property (
        !$past(rd_en) |-> rd_data == 8'h00)
        else $error("read data outside read slot");
endmodule // supply_monitor_checker

// file: test/supply_monitor_reset_logic_test.sv
// self-checking bench for the supply monitor reset logic
`timescale 1ns/1ps
`include "supply_monitor_consts.vh"
module supply_monitor_reset_logic_test;
    // ============================================================
    // signals
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg pin_low = 1'b0;
    reg [7:0] vcc = 8'h21;
    reg [1:0] option = 2'h3;
    reg wdt_underflow = 1'b0;
    reg wdt_refresh_err = 1'b0;
    reg [7:0] addr = 8'h00;
    reg [7:0] wr_data = 8'h00;
    reg wr_en = 1'b0;
    reg rd_en = 1'b0;
    reg [7:0] v;
    wire [7:0] rd_data;
    wire [1:0] lvl0;
    wire [3:0] lvl1;
    wire [1:0] lvl2;
    wire por_above, mon0_above, mon1_above, mon2_above, pin_n;
    wire sys_reset, irq, nmi;
    integer n, i, cycles = 0, n_mismatch = 0, tests_run = 0;

    initial begin
        forever #25 clk = ~clk;
    end

    supply_model i_model (.vcc(vcc), .pin_low(pin_low),
        .monitor0_level_select(lvl0), .monitor1_level_field(lvl1),
        .monitor2_level_field(lvl2), .por_above(por_above),
        .mon0_above(mon0_above), .mon1_above(mon1_above),
        .mon2_above(mon2_above), .ext_reset_pin_n(pin_n));

    supply_monitor_reset_logic i_dut (.clk(clk), .rst(rst),
        .ext_reset_pin_n(pin_n), .por_above(por_above),
        .mon0_above(mon0_above), .mon1_above(mon1_above),
        .mon2_above(mon2_above), .option_config_word_1(option),
        .wdt_underflow(wdt_underflow), .wdt_refresh_err(wdt_refresh_err),
        .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data(rd_data), .monitor0_level_select(lvl0),
        .monitor1_level_field(lvl1), .monitor2_level_field(lvl2),
        .sys_reset(sys_reset), .irq(irq), .nmi(nmi));

    // ============================================================
    // tasks
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", tests_run, n_mismatch);
            if (n_mismatch == 0 && tests_run > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask

    task chk(input [8*8-1:0] name, input [7:0] exp, input [7:0] got);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("unexpected %0s exp %h got %h", name, exp, got);
            end
        end
    endtask

    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wr_data <= d;
            wr_en <= 1'b1;
            @(posedge clk);
            wr_en <= 1'b0;
        end
    endtask

    task rdc(input [8*8-1:0] name, input [7:0] a, input [7:0] m,
        input [7:0] exp);
        begin
            @(posedge clk);
            addr <= a;
            rd_en <= 1'b1;
            @(posedge clk);
            rd_en <= 1'b0;
            #1 v = rd_data;
            chk(name, exp, v & m);
        end
    endtask

    task pulse_wdt(input e);
        begin
            @(posedge clk);
            wdt_underflow <= !e;
            wdt_refresh_err <= e;
            @(posedge clk);
            wdt_underflow <= 1'b0;
            wdt_refresh_err <= 1'b0;
        end
    endtask

    // counts cycles until the reset output drops, bounded
    task wait_rel;
        begin
            n = 0;
            while (sys_reset !== 1'b0 && n < 2200) begin
                @(negedge clk);
                n = n + 1;
            end
            chk("release", 8'h00, {7'h00, sys_reset});
        end
    endtask

    task settle(input integer k);
        begin
            repeat (k) @(negedge clk);
        end
    endtask

    // ============================================================
    // hang guard: the whole sequence needs about 21200 cycles
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 40000) begin
            n_mismatch = n_mismatch + 1;
            finish_test;
        end
    end

    // ============================================================
    // sequence
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        wait_rel;
        rdc("cause", `OFS_RST_CAUSE, 8'hFF, 8'h02);
        chk("lvl0", 8'h02, {6'h00, lvl0});
        rdc("ctl1", `OFS_MON1_CTL, 8'hFF, 8'h00);
        rdc("mask", `OFS_INT_MASK, 8'hFF, 8'h00);
        rdc("unmapd", 8'h24, 8'hFF, 8'h00);
        wr(`OFS_LEVEL_SEL, 8'h38);
        rdc("lvl", `OFS_LEVEL_SEL, 8'hFF, 8'h38);
        wr(`OFS_LEVEL_SEL, 8'h09);
        rdc("lvl", `OFS_LEVEL_SEL, 8'hFF, 8'h08);
        chk("lvl1", 8'h08, {4'h0, lvl1});
        wr(`OFS_LEVEL_SEL, 8'h32);
        rdc("lvl", `OFS_LEVEL_SEL, 8'hFF, 8'h32);
        chk("lvl2", 8'h03, {6'h00, lvl2});
        wr(`OFS_SW_RESET, 8'h5A);
        settle(3);
        chk("reset", 8'h00, {7'h00, sys_reset});
        // watchdog underflow, refresh error, then software key
        for (i = 0; i < 3; i = i + 1) begin
            wr(`OFS_RST_CAUSE, 8'hFF);
            if (i == 2)
                wr(`OFS_SW_RESET, `SW_RESET_KEY);
            else
                pulse_wdt(i[0]);
            settle(2);
            chk("reset", 8'h01, {7'h00, sys_reset});
            wait_rel;
            rdc("cause", `OFS_RST_CAUSE, 8'hFF,
                (i == 2) ? 8'h40 : 8'h20);
        end
        // pin held low, then supply under channel 0
        for (i = 0; i < 2; i = i + 1) begin
            wr(`OFS_RST_CAUSE, 8'hFF);
            if (i == 0)
                pin_low <= 1'b1;
            else
                vcc <= 8'h15;
            settle(2500);
            chk("reset", 8'h01, {7'h00, sys_reset});
            @(posedge clk);
            pin_low <= 1'b0;
            vcc <= 8'h21;
            wait_rel;
            chk("delay", 8'h01, {7'h00, n >= 2000 && n <= 2010});
            rdc("cause", `OFS_RST_CAUSE, 8'hFF,
                (i == 0) ? 8'h01 : 8'h04);
        end
        // interrupts: channel 1 maskable on both edges, 2 nmi on falling
        wr(`OFS_MON1_STAT, 8'hFF);
        wr(`OFS_INT_MASK, 8'h01);
        wr(`OFS_MON1_CTL, 8'h24);
        wr(`OFS_MON2_CTL, 8'h0C);
        @(posedge clk);
        vcc <= 8'h1F;
        settle(8);
        chk("irq", 8'h01, {7'h00, irq});
        chk("nmi", 8'h00, {7'h00, nmi});
        rdc("stat1", `OFS_MON1_STAT, 8'hFF, 8'h01);
        wr(`OFS_INT_STAT, 8'h01);
        wr(`OFS_INT_MASK, 8'h00);
        @(posedge clk);
        vcc <= 8'h21;
        settle(8);
        chk("irq", 8'h00, {7'h00, irq});
        rdc("istat", `OFS_INT_STAT, 8'hFF, 8'h01);
        rdc("stat1", `OFS_MON1_STAT, 8'hFF, 8'h03);
        wr(`OFS_INT_MASK, 8'h01);
        settle(3);
        chk("irq", 8'h01, {7'h00, irq});
        wr(`OFS_INT_STAT, 8'h01);
        @(posedge clk);
        vcc <= 8'h1C;
        settle(8);
        chk("nmi", 8'h01, {7'h00, nmi});
        rdc("istat", `OFS_INT_STAT, 8'hFF, 8'h09);
        wr(`OFS_INT_STAT, 8'h09);
        @(posedge clk);
        vcc <= 8'h21;
        settle(8);
        chk("nmi", 8'h00, {7'h00, nmi});
        rdc("istat", `OFS_INT_STAT, 8'hFF, 8'h01);
        rdc("stat2", `OFS_MON2_STAT, 8'hFF, 8'h03);
        // channel 1 nmi on both edges, channel 2 maskable on rise only
        wr(`OFS_INT_STAT, 8'h0F);
        wr(`OFS_MON1_CTL, 8'h2C);
        wr(`OFS_MON2_CTL, 8'h14);
        wr(`OFS_INT_MASK, 8'h02);
        @(posedge clk);
        vcc <= 8'h1C;
        settle(8);
        chk("nmi", 8'h01, {7'h00, nmi});
        chk("irq", 8'h00, {7'h00, irq});
        rdc("istat", `OFS_INT_STAT, 8'hFF, 8'h04);
        @(posedge clk);
        vcc <= 8'h21;
        settle(8);
        chk("irq", 8'h01, {7'h00, irq});
        rdc("istat", `OFS_INT_STAT, 8'hFF, 8'h06);
        wr(`OFS_INT_STAT, 8'h0F);
        // channel 1 reset released after the fall, then after the rise
        wr(`OFS_MON2_CTL, 8'h00);
        wr(`OFS_MON1_CTL, 8'h03);
        @(posedge clk);
        vcc <= 8'h1F;
        settle(6);
        chk("reset", 8'h01, {7'h00, sys_reset});
        wait_rel;
        chk("delay", 8'h01, {7'h00, n >= 1980 && n <= 2005});
        wr(`OFS_MON1_CTL, 8'h01);
        settle(6);
        chk("reset", 8'h01, {7'h00, sys_reset});
        @(posedge clk);
        vcc <= 8'h21;
        wait_rel;
        chk("delay", 8'h01, {7'h00, n >= 2000 && n <= 2010});
        finish_test;
    end
endmodule // supply_monitor_reset_logic_test

bind supply_monitor_reset_logic supply_monitor_checker i_chk (
    .clk(clk), .rst(rst), .ext_reset_pin_n(ext_reset_pin_n),
    .mon0_above(mon0_above), .wdt_underflow(wdt_underflow),
    .wdt_refresh_err(wdt_refresh_err), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .monitor0_level_select(monitor0_level_select),
    .monitor1_level_field(monitor1_level_field), .sys_reset(sys_reset));
